/* ooc_pkg.sv */
// Constants, types and timing figures of the on/off switcher controller
`default_nettype none
// Function
// - Capture feedback comparator a fixed 2.5 us after every switch turn-off.
// - In voltage mode, enable or skip cycles to hold feedback at threshold.
// - In current mode, raise switching frequency as feedback level rises.
// - Reaching threshold from current mode enters voltage mode at maximum frequency.
// - Select the reduced peak current limit at light load.
// - In voltage mode, raise feedback reference with load to offset cable drop.
// - Estimate load from on/off machine output, not from current sensing.
// - Supply capacitor size selects 0.4 or 0.75 ohm cable compensation.
// - Feedback low past about 300 ms starts auto-restart, off for 1.2 s.
// - Auto-restart alternates enabled and disabled intervals until fault clears.
// - Open loop shortens enabled interval to 6 cycles, keeping 1.2 s off.
// - Above 142 C stop switching; resume once 60 C cooler.
// - Switch current over threshold ends the switch on-time for that cycle.
// - Ignore current limit for a short blanking time after turn-on.
// - Supply charger runs only while the switch is off.
// - Maximum switching frequency 105 kHz with frequency jitter.
// - Outside auto-restart off and thermal shutdown, a cycle is forced at the next oscillator start once 1/1.4 kHz passes without one.
package ooc_pkg;
    localparam int CLK_MHZ                  = 25;
    localparam int CLK_HZ                   = CLK_MHZ * 1_000_000;
    localparam int FB_SAMPLE_NS             = 2500;
    localparam int FB_SAMPLE_CYC            = (FB_SAMPLE_NS * CLK_MHZ + 999) / 1000;
    localparam int FREQ_MAX_HZ              = 105_000;
    localparam int PERIOD_CYC               = CLK_HZ / FREQ_MAX_HZ;
    localparam int JITTER_PCT               = 7;
    localparam int JITTER_CYC               = PERIOD_CYC * JITTER_PCT / 100;
    localparam int DUTY_MAX_PCT             = 55;
    localparam int ON_MAX_CYC               = PERIOD_CYC * DUTY_MAX_PCT / 100;
    localparam int TURN_ON_BLANKING_TIME_NS = 200;
    localparam int BLANK_CYC                = (TURN_ON_BLANKING_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int FREQ_MIN_HZ              = 1400;
    localparam int MIN_RATE_CYC             = CLK_HZ / FREQ_MIN_HZ;
    localparam int FAULT_PERSIST_MS         = 300;
    localparam int FAULT_PERSIST_CYC        = FAULT_PERSIST_MS * CLK_MHZ * 1000;
    localparam int AR_OFF_MS                = 1200;
    localparam int AR_OFF_CYC               = AR_OFF_MS * CLK_MHZ * 1000;
    localparam int OPEN_LOOP_CYCLES         = 6;
    localparam int LOAD_WIN                 = 16;
    localparam int PERIOD_W                 = 10;
    localparam int TIMER_W                  = 8;
    localparam int FB_W                     = 8;
    localparam int LOAD_W                   = 5;
    localparam int COMP_W                   = 4;
    localparam int OL_W                     = 3;
    localparam int WIN_W                    = 4;
    localparam int PIN_N                    = 7;
    localparam int COMP_SHIFT               = 4;
    localparam logic [FB_W-1:0]     FB_CV_CODE    = 8'hC0;
    localparam logic [PERIOD_W-1:0] PERIOD_T      = PERIOD_W'(PERIOD_CYC);
    localparam logic [PERIOD_W-1:0] JIT_T         = PERIOD_W'(JITTER_CYC);
    localparam logic [PERIOD_W-1:0] JIT2_T        = PERIOD_W'(2 * JITTER_CYC);
    localparam logic [TIMER_W-1:0]  ON_LAST_T     = TIMER_W'(ON_MAX_CYC - 1);
    localparam logic [TIMER_W-1:0]  BLANK_T       = TIMER_W'(BLANK_CYC);
    localparam logic [TIMER_W-1:0]  SAMPLE_T      = TIMER_W'(FB_SAMPLE_CYC - 1);
    localparam logic [OL_W-1:0]     OL_T          = OL_W'(OPEN_LOOP_CYCLES);
    localparam logic [WIN_W-1:0]    WIN_LAST_T    = WIN_W'(LOAD_WIN - 1);
    localparam logic [LOAD_W-1:0]   LIGHT_T       = 5'h04;
    localparam logic [COMP_W-1:0]   NUM_SMALL_T   = 4'h8;
    localparam logic [COMP_W-1:0]   NUM_LARGE_T   = 4'hF;
    localparam logic [1:0]          STRAP_T       = 2'h2;
    typedef enum logic [2:0] {
        ST_IDLE   = 3'h1,
        ST_ON     = 3'h2,
        ST_SAMPLE = 3'h4
    } ooc_state_t;
endpackage
`default_nettype wire

/* ooc_osc_if.sv */
// Oscillator link between controller and cycle oscillator
`timescale 1ns/100ps
`default_nettype none
interface ooc_osc_if;
    logic [ooc_pkg::PERIOD_W-1:0] period_base;
    logic                         cycle_start;
    modport osc  (input period_base, output cycle_start);
    modport ctrl (output period_base, input cycle_start);
endinterface
`default_nettype wire

/* ooc_sync.sv */
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/100ps
`default_nettype none
module ooc_sync #(
    parameter int W = 1
) (
    input  wire logic         ref_clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule
`default_nettype wire

/* ooc_osc.sv */
// Cycle oscillator with triangular period jitter
`timescale 1ns/100ps
`default_nettype none
module ooc_osc (
    input  wire logic ref_clk,
    input  wire logic rst,
    ooc_osc_if.osc    osc
);
    import ooc_pkg::*;

    logic [PERIOD_W-1:0] cnt;
    logic [PERIOD_W-1:0] jit_pos;
    logic                jit_up;
    logic [PERIOD_W-1:0] cur_last;
    logic                wrap;

    // Jitter swings the period around its base value
    assign cur_last = osc.period_base - JIT_T + jit_pos - 10'h001;
    assign wrap     = (cnt >= cur_last);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cnt             <= '0;
            osc.cycle_start <= 1'h0;
        end else begin
            cnt             <= wrap ? '0 : cnt + 1'h1;
            osc.cycle_start <= wrap;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            jit_pos <= JIT_T;
            jit_up  <= 1'h1;
        end else if (wrap) begin
            if (jit_up) begin
                if (jit_pos >= JIT2_T) begin
                    jit_up <= 1'h0;
                end else begin
                    jit_pos <= jit_pos + 1'h1;
                end
            end else begin
                if (jit_pos == '0) begin
                    jit_up <= 1'h1;
                end else begin
                    jit_pos <= jit_pos - 1'h1;
                end
            end
        end
    end

    chk_jitter_span: assert property (@(posedge ref_clk) disable iff (rst)
        jit_pos <= JIT2_T)
        else $error("jitter offset out of range");
endmodule
`default_nettype wire

/* ooc_ctrl.sv */
// Control state machine of the on/off flyback switcher
`timescale 1ns/100ps
`default_nettype none
module ooc_ctrl #(
    parameter int FAULT_PERSIST_CYCLES = ooc_pkg::FAULT_PERSIST_CYC,
    parameter int AR_OFF_CYCLES        = ooc_pkg::AR_OFF_CYC,
    parameter int MIN_RATE_CYCLES      = ooc_pkg::MIN_RATE_CYC,
    parameter int AR_W                 = 25,
    parameter int IDLE_W               = 16
) (
    input  wire logic                     ref_clk,
    input  wire logic                     rst,
    input  wire logic                     feedback_sense_above,
    input  wire logic                     feedback_sense_low,
    input  wire logic                     feedback_sense_open,
    input  wire logic                     switch_current_over,
    input  wire logic                     temp_over,
    input  wire logic                     temp_cool,
    input  wire logic                     supply_capacitor_value,
    input  wire logic [ooc_pkg::FB_W-1:0] feedback_level,
    output logic                          switch_gate,
    output logic                          charger_en,
    output logic                          current_limit_low,
    output logic [ooc_pkg::COMP_W-1:0]    feedback_ref_trim,
    output logic                          cv_mode,
    output logic                          auto_restart_off,
    output logic                          open_loop,
    output logic                          thermal_off
);
    import ooc_pkg::*;

    localparam int SAMPLE_DLY = FB_SAMPLE_CYC;
    localparam logic [AR_W-1:0]   PERSIST_LAST  = AR_W'(FAULT_PERSIST_CYCLES - 1);
    localparam logic [AR_W-1:0]   AR_OFF_LAST   = AR_W'(AR_OFF_CYCLES - 1);
    localparam logic [IDLE_W-1:0] MIN_RATE_LAST = IDLE_W'(MIN_RATE_CYCLES - 1);

    // ------------------------------------------------------------
    // Pin synchronisers and oscillator
    // ------------------------------------------------------------
    logic [PIN_N-1:0] pin_raw;
    logic [PIN_N-1:0] pin_sync;
    logic             s_above;
    logic             s_low;
    logic             s_open;
    logic             s_ilim;
    logic             s_hot;
    logic             s_cool;
    logic             s_large;

    assign pin_raw = {supply_capacitor_value, temp_cool, temp_over, switch_current_over,
                      feedback_sense_open, feedback_sense_low, feedback_sense_above};
    assign {s_large, s_cool, s_hot, s_ilim, s_open, s_low, s_above} = pin_sync;

    ooc_sync #(
        .W (PIN_N)
    ) u_sync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .d       (pin_raw),
        .q       (pin_sync)
    );

    ooc_osc_if osc_bus ();

    ooc_osc u_osc (
        .ref_clk (ref_clk),
        .rst     (rst),
        .osc     (osc_bus.osc)
    );

    // ------------------------------------------------------------
    // Internal state
    // ------------------------------------------------------------
    ooc_state_t          state;
    ooc_state_t          next_state;
    logic [TIMER_W-1:0]  tcnt;
    logic                fb_sample;
    logic                fb_low;
    logic [OL_W-1:0]     ol_cnt;
    logic [AR_W-1:0]     ar_cnt;
    logic [IDLE_W-1:0]   idle_cnt;
    logic [WIN_W-1:0]    win_cnt;
    logic [LOAD_W-1:0]   on_cnt;
    logic [LOAD_W-1:0]   load_est;
    logic                comp_large;
    logic [1:0]          strap_cnt;
    logic                strap_done;
    logic                run_ok;
    logic                min_due;
    logic                fire;
    logic                ilim_hit;
    logic                on_end;
    logic                sample_now;
    logic                ol_trip;
    logic                next_switch;
    logic [LOAD_W+COMP_W-1:0] comp_prod;

    assign run_ok     = ~auto_restart_off & ~thermal_off;
    assign min_due    = (idle_cnt >= MIN_RATE_LAST);
    // Voltage mode skips a cycle when the last sample stood above threshold and the minimum rate is not due
    assign fire       = osc_bus.cycle_start & run_ok & (state == ST_IDLE)
                      & (~cv_mode | ~fb_sample | min_due);
    assign ilim_hit   = s_ilim & (tcnt >= BLANK_T);
    assign on_end     = (state == ST_ON) & ((tcnt == ON_LAST_T) | ilim_hit | ~run_ok);
    assign sample_now = (state == ST_SAMPLE) & (tcnt == SAMPLE_T);
    assign ol_trip    = (ol_cnt >= OL_T);
    assign next_switch = (next_state == ST_ON);

    // ------------------------------------------------------------
    // Switching state machine
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (fire) begin
                    next_state = ST_ON;
                end
            end
            ST_ON: begin
                if (on_end) begin
                    next_state = ST_SAMPLE;
                end
            end
            ST_SAMPLE: begin
                if (sample_now) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state <= ST_IDLE;
            tcnt  <= '0;
        end else begin
            state <= next_state;
            if (state != next_state) begin
                tcnt <= '0;
            end else if (state != ST_IDLE) begin
                tcnt <= tcnt + 1'h1;
            end
        end
    end

    // Charger is the exact complement of the gate
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            switch_gate <= 1'h0;
            charger_en  <= 1'h1;
        end else begin
            switch_gate <= next_switch;
            charger_en  <= ~next_switch;
        end
    end

    // ------------------------------------------------------------
    // Feedback sampling
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fb_sample <= 1'h0;
            fb_low    <= 1'h0;
        end else if (sample_now) begin
            fb_sample <= s_above;
            fb_low    <= s_low;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            open_loop <= 1'h0;
        end else if (on_end) begin
            open_loop <= s_open;
        end
    end

    // ------------------------------------------------------------
    // Mode and frequency
    // ------------------------------------------------------------
    // Period shrinks as feedback rises and bottoms out at the threshold
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cv_mode             <= 1'h0;
            osc_bus.period_base <= PERIOD_T;
        end else if (feedback_level >= FB_CV_CODE) begin
            cv_mode             <= 1'h1;
            osc_bus.period_base <= PERIOD_T;
        end else begin
            cv_mode             <= 1'h0;
            osc_bus.period_base <= PERIOD_T + PERIOD_W'(FB_CV_CODE - feedback_level);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst || !run_ok || fire) begin
            idle_cnt <= '0;
        end else if (!min_due) begin
            idle_cnt <= idle_cnt + 1'h1;
        end
    end

    // ------------------------------------------------------------
    // Load estimate and cable compensation
    // ------------------------------------------------------------
    // Load is the count of enabled cycles in a window of cycles
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            win_cnt  <= '0;
            on_cnt   <= '0;
            load_est <= '0;
        end else if (osc_bus.cycle_start) begin
            if (win_cnt == WIN_LAST_T) begin
                win_cnt  <= '0;
                on_cnt   <= '0;
                load_est <= on_cnt + LOAD_W'(fire);
            end else begin
                win_cnt <= win_cnt + 1'h1;
                on_cnt  <= on_cnt + LOAD_W'(fire);
            end
        end
    end

    // Capacitor size is caught once, after the synchroniser has filled
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            strap_cnt  <= '0;
            strap_done <= 1'h0;
            comp_large <= 1'h0;
        end else if (!strap_done) begin
            if (strap_cnt == STRAP_T) begin
                comp_large <= s_large;
                strap_done <= 1'h1;
            end else begin
                strap_cnt <= strap_cnt + 1'h1;
            end
        end
    end

    assign comp_prod = load_est * (comp_large ? NUM_LARGE_T : NUM_SMALL_T);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            feedback_ref_trim <= '0;
            current_limit_low <= 1'h0;
        end else begin
            current_limit_low <= cv_mode & (load_est < LIGHT_T);
            if (cv_mode) begin
                feedback_ref_trim <= comp_prod[COMP_SHIFT +: COMP_W];
            end else begin
                feedback_ref_trim <= '1;
            end
        end
    end

    // ------------------------------------------------------------
    // Auto-restart and thermal protection
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ar_cnt           <= '0;
            ol_cnt           <= '0;
            auto_restart_off <= 1'h0;
        end else if (auto_restart_off) begin
            ol_cnt <= '0;
            if (ar_cnt == AR_OFF_LAST) begin
                ar_cnt           <= '0;
                auto_restart_off <= 1'h0;
            end else begin
                ar_cnt <= ar_cnt + 1'h1;
            end
        end else if (ol_trip) begin
            ar_cnt           <= '0;
            auto_restart_off <= 1'h1;
        end else begin
            if (on_end) begin
                ol_cnt <= s_open ? ol_cnt + 1'h1 : '0;
            end
            if (fb_low && !thermal_off) begin
                if (ar_cnt == PERSIST_LAST) begin
                    ar_cnt           <= '0;
                    auto_restart_off <= 1'h1;
                end else begin
                    ar_cnt <= ar_cnt + 1'h1;
                end
            end else begin
                ar_cnt <= '0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            thermal_off <= 1'h0;
        end else if (s_hot) begin
            thermal_off <= 1'h1;
        end else if (s_cool) begin
            thermal_off <= 1'h0;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_charger_gate: assert property (@(posedge ref_clk) disable iff (rst)
        switch_gate |-> !charger_en)
        else $error("charger enabled while switch on");

    chk_sample_delay: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(switch_gate) |-> ##SAMPLE_DLY (fb_sample == $past(s_above)))
        else $error("feedback not sampled at fixed delay");

    chk_cv_skip: assert property (@(posedge ref_clk) disable iff (rst)
        osc_bus.cycle_start && cv_mode && fb_sample && !min_due |=> !switch_gate)
        else $error("cycle not skipped above threshold");

    chk_cc_fire: assert property (@(posedge ref_clk) disable iff (rst)
        osc_bus.cycle_start && run_ok && !cv_mode && state == ST_IDLE |=> switch_gate)
        else $error("current mode cycle not taken");

    chk_cv_period: assert property (@(posedge ref_clk) disable iff (rst)
        cv_mode |-> osc_bus.period_base == PERIOD_T)
        else $error("voltage mode not at maximum frequency");

    chk_ilim_cut: assert property (@(posedge ref_clk) disable iff (rst)
        state == ST_ON && s_ilim && tcnt >= BLANK_T |=> !switch_gate)
        else $error("current limit did not end on-time");

    chk_blank_hold: assert property (@(posedge ref_clk) disable iff (rst)
        state == ST_ON && tcnt < BLANK_T && run_ok |=> switch_gate)
        else $error("switch ended inside blanking");

    chk_thermal_off: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(thermal_off) |=> !switch_gate [*2])
        else $error("switching during thermal shutdown");

    chk_ar_quiet: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(auto_restart_off) |=> (!switch_gate) [*8])
        else $error("switching during auto-restart off");

    chk_ol_trip: assert property (@(posedge ref_clk) disable iff (rst)
        ol_trip && !auto_restart_off |=> auto_restart_off)
        else $error("open loop did not start auto-restart");

    chk_min_rate: assert property (@(posedge ref_clk) disable iff (rst)
        osc_bus.cycle_start && min_due && run_ok && state == ST_IDLE |=> switch_gate)
        else $error("minimum rate cycle not forced");

    chk_light_limit: assert property (@(posedge ref_clk) disable iff (rst)
        current_limit_low |-> $past(load_est) < LIGHT_T && $past(cv_mode))
        else $error("reduced limit outside light load");
endmodule
`default_nettype wire

/* ooc_bias_model.sv */
// Bias winding feedback and power switch sensing model
`timescale 1ns/100ps
`default_nettype none
module ooc_bias_model (
    input  wire logic       ref_clk,
    input  wire logic       switch_gate,
    input  wire logic       fb_high,
    input  wire logic       fb_short,
    input  wire logic       fb_open,
    input  wire logic [7:0] oc_delay,
    output logic            feedback_sense_above,
    output logic            feedback_sense_low,
    output logic            feedback_sense_open,
    output logic            switch_current_over
);
    logic [7:0] on_cnt = 8'h00;
    // Primary current ramps while on; trips after oc_delay cycles, zero never trips
    always_ff @(posedge ref_clk) begin
        on_cnt <= switch_gate ? on_cnt + 8'h01 : 8'h00;
    end
    assign switch_current_over  = switch_gate && (oc_delay != 8'h00) && (on_cnt >= oc_delay);
    assign feedback_sense_above = fb_high;
    assign feedback_sense_low   = fb_short;
    assign feedback_sense_open  = fb_open;
endmodule
`default_nettype wire

/* ooc_ctrl_bench.sv */
// Self-checking testbench of the on/off switcher controller
`timescale 1ns/100ps
`default_nettype none
module ooc_ctrl_bench;
    import ooc_pkg::*;
    logic ref_clk = 0, rst = 1, temp_over = 0, temp_cool = 0, supply_capacitor_value = 1;
    logic fb_high = 0, fb_short = 0, fb_open = 0;
    logic [7:0] oc_delay = 8'h00;
    logic [FB_W-1:0] feedback_level = 8'hC0;
    logic feedback_sense_above, feedback_sense_low, feedback_sense_open, switch_current_over;
    logic switch_gate, charger_en, current_limit_low, cv_mode, auto_restart_off, open_loop, thermal_off;
    logic [COMP_W-1:0] feedback_ref_trim;
    int err_count = 0, n_checks = 0, n, p, q;

    always #20 ref_clk = ~ref_clk;

    ooc_ctrl #(.FAULT_PERSIST_CYCLES(200), .AR_OFF_CYCLES(300), .MIN_RATE_CYCLES(1000)) ooc_ctrl_i (
        .ref_clk, .rst, .feedback_sense_above, .feedback_sense_low, .feedback_sense_open,
        .switch_current_over, .temp_over, .temp_cool, .supply_capacitor_value, .feedback_level,
        .switch_gate, .charger_en, .current_limit_low, .feedback_ref_trim, .cv_mode,
        .auto_restart_off, .open_loop, .thermal_off);
    ooc_bias_model ooc_bias_model_i (.ref_clk, .switch_gate, .fb_high, .fb_short, .fb_open, .oc_delay,
        .feedback_sense_above, .feedback_sense_low, .feedback_sense_open, .switch_current_over);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic step(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask
    task automatic chk_bit(input logic act, input logic exp, input string msg);
        n_checks++;
        if (act !== exp) begin
            err_count++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask
    task automatic chk_range(input int act, input int lo, input int hi, input string msg);
        n_checks++;
        if (act < lo || act > hi) begin
            err_count++;
            $display("[ERR] %0t %s %0d", $time, msg, act);
        end
    endtask
    task automatic wait_lvl(ref logic s, input logic lvl, input int lim, output int k);
        k = 0;
        while (s !== lvl && k < lim) begin
            step(1);
            k++;
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    // Rise-to-rise switching period, skipping the period already running
    task automatic t_per(output int t);
        int k;
        wait_lvl(switch_gate, 0, 400, k);
        wait_lvl(switch_gate, 1, 2000, k);
        wait_lvl(switch_gate, 0, 400, t);
        wait_lvl(switch_gate, 1, 2000, k);
        t = t + k;
    endtask
    task automatic t_cv_cycle;
        wait_lvl(switch_gate, 1, 400, n);
        chk_range(n, 0, 399, "no cycle start");
        chk_bit(charger_en, 0, "charger on while switch on");
        chk_bit(cv_mode, 1, "not voltage mode");
        wait_lvl(switch_gate, 0, 400, n);
        chk_range(n, 130, 130, "on-time");
        chk_bit(charger_en, 1, "charger off while switch off");
        step(2);
        chk_bit(current_limit_low, 1, "light load limit");
        $display("t_cv_cycle done");
    endtask
    task automatic t_limit(input logic [7:0] d, input int lo, input int hi);
        oc_delay = d;
        wait_lvl(switch_gate, 1, 2000, n);
        wait_lvl(switch_gate, 0, 400, n);
        chk_range(n, lo, hi, "limited on-time");
        oc_delay = 8'h00;
        $display("t_limit done");
    endtask
    // Sample above threshold skips cycles until the minimum rate forces one
    task automatic t_skip;
        fb_high = 1;
        wait_lvl(switch_gate, 1, 2000, n);
        chk_range(n, 950, 1250, "skip until minimum rate");
        fb_high = 0;
        $display("t_skip done");
    endtask
    // Period is base plus threshold distance, within the jitter swing
    task automatic t_cc;
        feedback_level = 8'h40;
        step(2);
        chk_bit(cv_mode, 0, "not current mode");
        chk_bit(feedback_ref_trim === 4'hF, 1, "trim in current mode");
        t_per(p);
        chk_range(p, 350, 382, "low feedback period");
        feedback_level = 8'h80;
        t_per(q);
        chk_range(q, 286, 318, "higher feedback period");
        feedback_level = 8'hC0;
        t_per(p);
        chk_range(p, 222, 254, "voltage mode period");
        chk_bit(cv_mode, 1, "not voltage mode at threshold");
        $display("t_cc done");
    endtask
    task automatic t_thermal;
        temp_over = 1;
        step(4);
        chk_bit(thermal_off, 1, "thermal not set");
        temp_over = 0;
        wait_lvl(switch_gate, 1, 600, n);
        chk_range(n, 600, 600, "switching while hot");
        temp_cool = 1;
        step(4);
        chk_bit(thermal_off, 0, "thermal not cleared");
        temp_cool = 0;
        wait_lvl(switch_gate, 1, 400, n);
        chk_range(n, 0, 399, "no restart after cooling");
        $display("t_thermal done");
    endtask
    task automatic t_restart(ref logic cause, input int lim);
        cause = 1;
        wait_lvl(auto_restart_off, 1, lim, n);
        chk_range(n, 1, lim - 1, "no auto-restart");
        if (fb_open)
            chk_bit(open_loop, 1, "open loop not flagged");
        step(1);
        chk_bit(switch_gate, 0, "switching in off period");
        wait_lvl(auto_restart_off, 0, 400, n);
        chk_range(n, 295, 305, "off period length");
        cause = 0;
        // Stale low sample may cost extra rounds; then it must stay enabled
        p = 0;
        for (int i = 0; i < 3000 && p < 600; i++) begin
            step(1);
            p = auto_restart_off ? 0 : p + 1;
        end
        chk_range(p, 600, 600, "auto-restart repeats after fault removed");
        $display("t_restart done");
    endtask
    task automatic t_reset;
        temp_over = 1;
        step(4);
        chk_bit(thermal_off, 1, "thermal not set before reset");
        temp_over = 0;
        rst = 1;
        step(4);
        chk_bit(switch_gate | thermal_off | auto_restart_off | open_loop, 0, "state kept over reset");
        chk_bit(charger_en, 1, "charger off in reset");
        rst = 0;
        wait_lvl(switch_gate, 1, 400, n);
        chk_range(n, 238, 240, "no enabled phase after reset");
        $display("t_reset done");
    endtask

    initial begin
        step(4);
        chk_bit(switch_gate, 0, "gate at reset");
        chk_bit(auto_restart_off | thermal_off, 0, "fault at reset");
        rst = 0;
        t_cv_cycle();
        t_limit(8'h01, 5, 9);
        t_limit(8'h14, 20, 26);
        t_skip();
        t_cc();
        t_thermal();
        t_restart(fb_short, 1200);
        t_restart(fb_open, 2400);
        t_reset();
        end_sim();
    end

    initial begin
        repeat (30000) @(posedge ref_clk);
        err_count++;
        end_sim();
    end
endmodule
`default_nettype wire
